// *** test/ipr_core_model.sv ***
// partner model: peripheral request lines and core exception entry and exit
`timescale 1ns/1ns
`default_nettype none
module ipr_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// commands from the bench
	input wire ipr_pkg::ipr_grp_t line_req,
	input wire logic [5:0] exc_id,
	input wire logic do_entry,
	input wire logic do_exit,
	// towards the register slice
	output ipr_pkg::ipr_grp_t irq_lines,
	output ipr_pkg::ipr_exc_t core_exc
);
	// ==========================================================
	// lines follow the request one edge late, like a peripheral flop would
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_lines <= '0;
		else
			irq_lines <= line_req;
	end
	// ==========================================================
	// entry and exit are one-cycle pulses; the id stays meaningful only with them
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			core_exc <= '0;
		else
			core_exc <= '{entry: do_entry, exit: do_exit, id: exc_id};
	end
endmodule : ipr_core_model
`default_nettype wire

// *** test/ipr_regs_test.sv ***
// bench: register slice checked over avalon-mm with a core and line model
`timescale 1ns/1ns
`default_nettype none
module ipr_regs_test;
	// ==========================================================
	// stimulus and observation
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [ipr_pkg::ADDR_W-1:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata, rdata_small, d, rd, rd_s, bit_v;
	logic avs_waitrequest, irq;
	ipr_pkg::ipr_grp_t line_req = '0;
	ipr_pkg::ipr_grp_t irq_lines;
	ipr_pkg::ipr_exc_t core_exc;
	ipr_pkg::ipr_prio_t prio_q;
	ipr_pkg::ipr_grp_t enable_q, pending_q, active_q;
	logic [5:0] exc_id = 6'h00;
	logic do_entry = 1'b0;
	logic do_exit = 1'b0;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [31:0] seed = 32'h0000_0053;
	logic [31:0] en [2];
	logic [31:0] pd [2];
	logic [31:0] pr;
	// ==========================================================
	// clock; the small build shares the bus to compare its active readback
	always #2 clk = ~clk;
	ipr_regs ipr_regs_i (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq_lines(irq_lines), .core_exc(core_exc),
		.enable_q(enable_q), .pending_q(pending_q), .active_q(active_q), .prio_q(prio_q),
		.irq(irq));
	ipr_regs #(.HAS_ACTIVE(1'b0)) ipr_regs_small_i (.clk(clk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(rdata_small), .avs_waitrequest(), .irq_lines(irq_lines),
		.core_exc(core_exc), .enable_q(), .pending_q(), .active_q(), .prio_q(), .irq());
	ipr_core_model ipr_core_model_i (.clk(clk), .arst_n(arst_n), .line_req(line_req),
		.exc_id(exc_id), .do_entry(do_entry), .do_exit(do_exit), .irq_lines(irq_lines),
		.core_exc(core_exc));
	// ==========================================================
	// helpers: xorshift source, byte-lane merge, bus cycle, compare, verdict
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++)
			if (be[b])
				o[8*b +: 8] = n[8*b +: 8];
		return o;
	endfunction : lanes
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// request held until waitrequest is seen low; an extra edge keeps drivers single
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		input logic [3:0] be);
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		do
		begin
			@(posedge clk);
		end
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rd_s = rdata_small;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
		check(rd, exp);
	endtask : rdchk
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		bus(1'b1, a, wd, 4'hf);
	endtask : wr
	// ==========================================================
	// watchdog: the whole sequence needs well under a tenth of this
	initial
	begin
		#200000;
		n_mismatch++;
		close_out();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		// every word from 0x00 to 0x3c reads zero out of reset, unmapped holes included
		for (int a = 0; a < 64; a += 4)
			rdchk(8'(a), 32'h0000_0000);
		en = '{32'h0, 32'h0};
		pd = '{32'h0, 32'h0};
		pr = 32'h0000_0000;
		// random set, pend and clear rounds on both groups, disable on group 1
		for (int i = 0; i < 6; i++)
		begin
			d = xs();
			wr(ipr_pkg::OFF_EN0, d);
			en[0] |= d & ipr_pkg::VALID0;
			d = xs();
			wr(ipr_pkg::OFF_EN1, d);
			en[1] |= d & ipr_pkg::VALID1;
			d = (i == 5) ? 32'h0000_0000 : xs();
			wr(ipr_pkg::OFF_DIS1, d);
			en[1] &= ~d;
			rdchk(ipr_pkg::OFF_EN0, en[0]);
			rdchk(ipr_pkg::OFF_DIS1, en[1]);
			rdchk(ipr_pkg::OFF_EN1, en[1]);
			check(enable_q.g0, en[0]);
			check(enable_q.g1, en[1]);
			for (int g = 0; g < 2; g++)
			begin
				d = (i == 5) ? 32'h0000_0000 : xs();
				wr(ipr_pkg::OFF_PSET0 + 8'(4*g), d);
				pd[g] |= d & (g ? ipr_pkg::VALID1 : ipr_pkg::VALID0);
				rdchk(ipr_pkg::OFF_PCLR0 + 8'(4*g), pd[g]);
				d = (i == 4) ? 32'h0000_0000 : xs();
				wr(ipr_pkg::OFF_PCLR0 + 8'(4*g), d);
				pd[g] &= ~d;
				rdchk(ipr_pkg::OFF_PSET0 + 8'(4*g), pd[g]);
			end
			check(pending_q.g0, pd[0]);
			check(pending_q.g1, pd[1]);
			d = (i == 0) ? 32'hffff_ffff : xs();
			bus(1'b1, ipr_pkg::OFF_PRIO0, d, (i == 0) ? 4'hf : d[3:0]);
			pr = lanes(pr, d, (i == 0) ? 4'hf : d[3:0]) & 32'he000_e0e0;
			rdchk(ipr_pkg::OFF_PRIO0, pr);
			check({23'h0, prio_q}, {23'h0, pr[31:29], pr[15:13], pr[7:5]});
		end
		// entry sets active and drops pending, exit clears; writes never touch it
		for (int k = 0; k < 2; k++)
		begin
			exc_id <= k ? 6'h28 : 6'h03;
			bit_v = k ? 32'h0000_0100 : 32'h0000_0008;
			wr(ipr_pkg::OFF_PSET0 + 8'(4*k), bit_v);
			wr(ipr_pkg::OFF_ACT0 + 8'(4*k), 32'hffff_ffff);
			rdchk(ipr_pkg::OFF_ACT0 + 8'(4*k), 32'h0000_0000);
			do_entry <= 1'b1;
			@(posedge clk);
			do_entry <= 1'b0;
			repeat (3) @(posedge clk);
			rdchk(ipr_pkg::OFF_ACT0 + 8'(4*k), bit_v);
			check(rd_s, 32'h0000_0000);
			check(k ? active_q.g1 : active_q.g0, bit_v);
			pd[k] &= ~bit_v;
			rdchk(ipr_pkg::OFF_PSET0 + 8'(4*k), pd[k]);
			do_exit <= 1'b1;
			@(posedge clk);
			do_exit <= 1'b0;
			repeat (3) @(posedge clk);
			rdchk(ipr_pkg::OFF_ACT0 + 8'(4*k), 32'h0000_0000);
		end
		// line event: sticky status, masked until enabled, cleared by one
		rdchk(ipr_pkg::OFF_STAT, 32'h0000_000c);
		// a line already pending raises no new event, so start from a clear bit
		wr(ipr_pkg::OFF_PCLR0, 32'h0000_0001);
		wr(ipr_pkg::OFF_STAT, 32'h0000_000f);
		line_req.g0 <= 32'h0000_0001;
		repeat (6) @(posedge clk);
		line_req <= '0;
		pd[0] |= 32'h0000_0001;
		rdchk(ipr_pkg::OFF_PSET0, pd[0]);
		rdchk(ipr_pkg::OFF_STAT, 32'h0000_0001);
		check({31'h0, irq}, 32'h0000_0000);
		wr(ipr_pkg::OFF_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0000_0001);
		line_req.g1 <= 32'h0000_0100;
		wr(ipr_pkg::OFF_STAT, 32'h0000_0001);
		repeat (6) @(posedge clk);
		line_req <= '0;
		check({31'h0, irq}, 32'h0000_0000);
		rdchk(ipr_pkg::OFF_STAT, 32'h0000_0002);
		rdchk(ipr_pkg::OFF_PCLR1, pd[1] | 32'h0000_0100);
		close_out();
	end
endmodule : ipr_regs_test
`default_nettype wire

// *** verilog/ipr_pkg.sv ***
// package: register map, field layout and carrier types of the interrupt register slice
package ipr_pkg;
	// ==========================================================
	// bus geometry
	localparam int ADDR_W = 8;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_EN0 = 8'h00;
	localparam logic [7:0] OFF_EN1 = 8'h04;
	localparam logic [7:0] OFF_DIS1 = 8'h0c;
	localparam logic [7:0] OFF_PSET0 = 8'h10;
	localparam logic [7:0] OFF_PSET1 = 8'h14;
	localparam logic [7:0] OFF_PCLR0 = 8'h18;
	localparam logic [7:0] OFF_PCLR1 = 8'h1c;
	localparam logic [7:0] OFF_ACT0 = 8'h20;
	localparam logic [7:0] OFF_ACT1 = 8'h24;
	localparam logic [7:0] OFF_PRIO0 = 8'h28;
	localparam logic [7:0] OFF_STAT = 8'h30;
	localparam logic [7:0] OFF_MASK = 8'h34;
	// ==========================================================
	// implemented interrupt bits of each group
	localparam logic [31:0] VALID0 = 32'hbfff_fffb;
	localparam logic [31:0] VALID1 = 32'h0000_011f;
	// ==========================================================
	// priority fields
	localparam int PRIO_W = 3;
	localparam int WDT_LSB = 5;
	localparam int BOD_LSB = 13;
	localparam int DMA_LSB = 29;
	// ==========================================================
	// event status bits
	localparam int STAT_W = 4;
	localparam int EV_HW0 = 0;
	localparam int EV_HW1 = 1;
	localparam int EV_ENTRY = 2;
	localparam int EV_EXIT = 3;
	// ==========================================================
	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [2:0] RST_PRIO = 3'h0;
	localparam logic [3:0] RST_STAT = 4'h0;
	// ==========================================================
	// carriers
	typedef struct packed {
		logic [31:0] g1;
		logic [31:0] g0;
	} ipr_grp_t;
	typedef struct packed {
		logic [2:0] dma;
		logic [2:0] bod;
		logic [2:0] wdt;
	} ipr_prio_t;
	typedef struct packed {
		logic entry;
		logic exit;
		logic [5:0] id;
	} ipr_exc_t;
endpackage : ipr_pkg

// *** verilog/ipr_regs.sv ***
// module: enable, pending, active and priority registers of the interrupt controller slice
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// What this block does
// R1: writing one to disable bit clears enable
// R2: disable register reads current enable state
// R3: second-group bits follow second enable layout
// R4: first-group bits follow first enable layout
// R5: writing one to pend-set makes pending
// R6: pend-set and pend-clear read pending state
// R7: writing one to pend-clear removes pending
// R8: active registers are read-only
// R9: active bit high while service runs
// R10: active registers absent in small build
// R11: unassigned bits are reserved
// R12: priority fields at 7:5, 15:13, 31:29
// R13: priority zero is most urgent
// R14: group0: watchdog 0, brown-out 1, dma 3
// R15: group1: bits 0 to 4 and 8 only
// R16: each priority field three bits wide
// R17: unused bits read zero, all reset zero
module ipr_regs #(
	parameter bit HAS_ACTIVE = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// avalon-mm slave
	input wire logic [ipr_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// peripheral request lines, asynchronous
	input wire ipr_pkg::ipr_grp_t irq_lines,
	// core exception entry and exit, same clock
	input wire ipr_pkg::ipr_exc_t core_exc,
	// state towards the arbiter
	output ipr_pkg::ipr_grp_t enable_q,
	output ipr_pkg::ipr_grp_t pending_q,
	output ipr_pkg::ipr_grp_t active_q,
	output ipr_pkg::ipr_prio_t prio_q,
	// event interrupt
	output logic irq
);
	// ==========================================================
	// helpers
	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic [31:0] one_hot(input logic [4:0] n);
		one_hot = 32'h0000_0001 << n;
	endfunction : one_hot

	// ==========================================================
	// declarations
	ipr_pkg::ipr_grp_t s1_ff;
	ipr_pkg::ipr_grp_t s2_ff;
	ipr_pkg::ipr_grp_t en_ff;
	ipr_pkg::ipr_grp_t pend_ff;
	ipr_pkg::ipr_grp_t act_ff;
	ipr_pkg::ipr_grp_t nxt_en;
	ipr_pkg::ipr_grp_t nxt_pend;
	ipr_pkg::ipr_grp_t nxt_act;
	ipr_pkg::ipr_grp_t ent_v;
	ipr_pkg::ipr_grp_t ext_v;
	ipr_pkg::ipr_grp_t pset_v;
	ipr_pkg::ipr_grp_t pclr_v;
	ipr_pkg::ipr_prio_t prio_ff;
	ipr_pkg::ipr_prio_t nxt_prio;
	logic [ipr_pkg::STAT_W-1:0] stat_ff;
	logic [ipr_pkg::STAT_W-1:0] mask_ff;
	logic [ipr_pkg::STAT_W-1:0] nxt_stat;
	logic [ipr_pkg::STAT_W-1:0] ev;
	logic [31:0] rdata_ff;
	logic [31:0] rd_mux;
	logic [31:0] wm;
	logic wait_ff;
	logic irq_ff;
	logic take;
	logic wstb;

	// ==========================================================
	// bus handshake
	// answer one cycle after the request is seen; strobe at the edge it is taken
	assign take = (avs_read | avs_write) & wait_ff;
	assign wstb = avs_write & ~wait_ff;
	assign wm = avs_writedata & be_mask(avs_byteenable);

	// waitrequest drops for exactly one cycle per request
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			wait_ff <= 1'b1;
		else
			wait_ff <= ~take;
	end

	// ==========================================================
	// request line synchroniser
	// lines come from other clocks, so two stages before any use
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
		end
		else
		begin
			s1_ff <= irq_lines;
			s2_ff <= s1_ff;
		end
	end

	// ==========================================================
	// exception entry and exit vectors
	// id bit 5 picks the group, low bits the interrupt
	always_comb
	begin
		ent_v = '0;
		ext_v = '0;
		if (core_exc.entry)
		begin
			if (core_exc.id[5])
				ent_v.g1 = one_hot(core_exc.id[4:0]);
			else
				ent_v.g0 = one_hot(core_exc.id[4:0]);
		end
		if (core_exc.exit)
		begin
			if (core_exc.id[5])
				ext_v.g1 = one_hot(core_exc.id[4:0]);
			else
				ext_v.g0 = one_hot(core_exc.id[4:0]);
		end
	end

	// ==========================================================
	// enable state
	always_comb
	begin
		nxt_en = en_ff;
		if (wstb && hit(avs_address, ipr_pkg::OFF_EN0))
			nxt_en.g0 = en_ff.g0 | wm;
		if (wstb && hit(avs_address, ipr_pkg::OFF_EN1))
			nxt_en.g1 = en_ff.g1 | wm;
		if (wstb && hit(avs_address, ipr_pkg::OFF_DIS1))
			nxt_en.g1 = en_ff.g1 & ~wm; // R1
		nxt_en.g0 = nxt_en.g0 & ipr_pkg::VALID0; // R4 R11 R14
		nxt_en.g1 = nxt_en.g1 & ipr_pkg::VALID1; // R3 R11 R15
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			en_ff <= '0; // R17
		else
			en_ff <= nxt_en;
	end

	// ==========================================================
	// pending state
	// a line or a set write beats a clear in the same cycle, so no event is lost
	always_comb
	begin
		pset_v = '0;
		pclr_v = '0;
		if (wstb && hit(avs_address, ipr_pkg::OFF_PSET0))
			pset_v.g0 = wm; // R5
		if (wstb && hit(avs_address, ipr_pkg::OFF_PSET1))
			pset_v.g1 = wm; // R5
		if (wstb && hit(avs_address, ipr_pkg::OFF_PCLR0))
			pclr_v.g0 = wm; // R7
		if (wstb && hit(avs_address, ipr_pkg::OFF_PCLR1))
			pclr_v.g1 = wm; // R7
		nxt_pend.g0 = (pend_ff.g0 & ~pclr_v.g0 & ~ent_v.g0) | pset_v.g0 | s2_ff.g0;
		nxt_pend.g1 = (pend_ff.g1 & ~pclr_v.g1 & ~ent_v.g1) | pset_v.g1 | s2_ff.g1;
		nxt_pend.g0 = nxt_pend.g0 & ipr_pkg::VALID0; // R4 R11
		nxt_pend.g1 = nxt_pend.g1 & ipr_pkg::VALID1; // R3 R11
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			pend_ff <= '0;
		else
			pend_ff <= nxt_pend;
	end

	// ==========================================================
	// active state, driven only by the core, never by a bus write
	always_comb
	begin
		nxt_act.g0 = ((act_ff.g0 & ~ext_v.g0) | ent_v.g0) & ipr_pkg::VALID0; // R9
		nxt_act.g1 = ((act_ff.g1 & ~ext_v.g1) | ent_v.g1) & ipr_pkg::VALID1; // R9
		if (!HAS_ACTIVE)
			nxt_act = '0; // R10
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			act_ff <= '0;
		else
			act_ff <= nxt_act; // R8
	end

	// ==========================================================
	// priority fields
	// only the three stored bits exist, so the quoted 32 levels fold into 8
	always_comb
	begin
		nxt_prio = prio_ff;
		if (wstb && hit(avs_address, ipr_pkg::OFF_PRIO0))
		begin
			if (avs_byteenable[0])
				nxt_prio.wdt = avs_writedata[ipr_pkg::WDT_LSB +: ipr_pkg::PRIO_W]; // R12 R16
			if (avs_byteenable[1])
				nxt_prio.bod = avs_writedata[ipr_pkg::BOD_LSB +: ipr_pkg::PRIO_W]; // R12 R16
			if (avs_byteenable[3])
				nxt_prio.dma = avs_writedata[ipr_pkg::DMA_LSB +: ipr_pkg::PRIO_W]; // R12 R16
		end
	end

	// lower value is more urgent; the arbiter compares fields as unsigned
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			prio_ff <= '{ipr_pkg::RST_PRIO, ipr_pkg::RST_PRIO, ipr_pkg::RST_PRIO}; // R17
		else
			prio_ff <= nxt_prio; // R13
	end

	// ==========================================================
	// event status, mask and interrupt
	always_comb
	begin
		ev = '0;
		ev[ipr_pkg::EV_HW0] = |(s2_ff.g0 & ~pend_ff.g0 & ipr_pkg::VALID0);
		ev[ipr_pkg::EV_HW1] = |(s2_ff.g1 & ~pend_ff.g1 & ipr_pkg::VALID1);
		ev[ipr_pkg::EV_ENTRY] = core_exc.entry;
		ev[ipr_pkg::EV_EXIT] = core_exc.exit;
		nxt_stat = stat_ff;
		if (wstb && hit(avs_address, ipr_pkg::OFF_STAT))
			nxt_stat = stat_ff & ~wm[ipr_pkg::STAT_W-1:0];
		nxt_stat = nxt_stat | ev; // set beats clear
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			stat_ff <= ipr_pkg::RST_STAT;
		else
			stat_ff <= nxt_stat;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			mask_ff <= ipr_pkg::RST_STAT;
		else if (wstb && hit(avs_address, ipr_pkg::OFF_MASK))
			mask_ff <= (mask_ff & ~{ipr_pkg::STAT_W{avs_byteenable[0]}})
				| wm[ipr_pkg::STAT_W-1:0];
	end

	// registered, so irq trails the status bit by one cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(stat_ff & mask_ff);
	end

	// ==========================================================
	// read mux; unmapped and absent registers read zero
	always_comb
	begin
		rd_mux = ipr_pkg::RST_WORD;
		case (avs_address)
			ipr_pkg::OFF_EN0: rd_mux = en_ff.g0;
			ipr_pkg::OFF_EN1: rd_mux = en_ff.g1;
			ipr_pkg::OFF_DIS1: rd_mux = en_ff.g1; // R2
			ipr_pkg::OFF_PSET0: rd_mux = pend_ff.g0; // R6
			ipr_pkg::OFF_PSET1: rd_mux = pend_ff.g1; // R6
			ipr_pkg::OFF_PCLR0: rd_mux = pend_ff.g0; // R6
			ipr_pkg::OFF_PCLR1: rd_mux = pend_ff.g1; // R6
			ipr_pkg::OFF_ACT0: rd_mux = HAS_ACTIVE ? act_ff.g0 : 32'h0; // R10
			ipr_pkg::OFF_ACT1: rd_mux = HAS_ACTIVE ? act_ff.g1 : 32'h0; // R10
			ipr_pkg::OFF_PRIO0:
			begin
				rd_mux[ipr_pkg::WDT_LSB +: ipr_pkg::PRIO_W] = prio_ff.wdt; // R17
				rd_mux[ipr_pkg::BOD_LSB +: ipr_pkg::PRIO_W] = prio_ff.bod;
				rd_mux[ipr_pkg::DMA_LSB +: ipr_pkg::PRIO_W] = prio_ff.dma;
			end
			ipr_pkg::OFF_STAT: rd_mux[ipr_pkg::STAT_W-1:0] = stat_ff;
			ipr_pkg::OFF_MASK: rd_mux[ipr_pkg::STAT_W-1:0] = mask_ff;
			default: rd_mux = ipr_pkg::RST_WORD;
		endcase
	end

	// read data is caught when the answer is prepared and held after
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_ff <= ipr_pkg::RST_WORD;
		else if (take && avs_read)
			rdata_ff <= rd_mux;
	end

	// ==========================================================
	// outputs
	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign enable_q = en_ff;
	assign pending_q = pend_ff;
	assign active_q = act_ff;
	assign prio_q = prio_ff;
	assign irq = irq_ff;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence bus_taken(logic [7:0] off);
		take && hit(avs_address, off) ##1 avs_write && !wait_ff;
	endsequence

	disable_clear_a: assert property (bus_taken(ipr_pkg::OFF_DIS1) |=> // R1
		(en_ff.g1 & $past(wm)) == 32'h0)
		else $error("disable write left enable set");

	disable_read_a: assert property (take && avs_read && hit(avs_address, ipr_pkg::OFF_DIS1) // R2
		|=> !avs_waitrequest && avs_readdata == $past(en_ff.g1))
		else $error("disable read not enable state");

	pend_set_a: assert property (bus_taken(ipr_pkg::OFF_PSET1) |=> // R5
		(pend_ff.g1 & $past(wm) & ipr_pkg::VALID1) == ($past(wm) & ipr_pkg::VALID1))
		else $error("pending set failed");

	pend_read_a: assert property (take && avs_read && hit(avs_address, ipr_pkg::OFF_PCLR0) // R6
		|=> avs_readdata == $past(pend_ff.g0))
		else $error("pending read mismatch");

	pend_clear_a: assert property (bus_taken(ipr_pkg::OFF_PCLR0) |=> // R7
		(pend_ff.g0 & $past(wm) & ~$past(s2_ff.g0)) == 32'h0)
		else $error("pending clear failed");

	act_write_a: assert property (avs_write && !wait_ff && !core_exc.entry // R8
		&& !core_exc.exit |=> $stable(act_ff))
		else $error("write changed active state");

	act_entry_a: assert property (core_exc.entry && !core_exc.id[5] && HAS_ACTIVE // R9
		&& ipr_pkg::VALID0[core_exc.id[4:0]] |=> act_ff.g0[$past(core_exc.id[4:0])]
		&& (!pend_ff.g0[$past(core_exc.id[4:0])] || $past(s2_ff.g0[core_exc.id[4:0]])))
		else $error("entry did not mark active");

	act_absent_a: assert property (!HAS_ACTIVE |-> act_ff == '0) // R10
		else $error("active state in small build");

	reserved_zero_a: assert property (((pend_ff.g1 | en_ff.g1 | act_ff.g1) // R11
		& ~ipr_pkg::VALID1) == 32'h0 && ((pend_ff.g0 | en_ff.g0) & ~ipr_pkg::VALID0) == 32'h0)
		else $error("reserved bit set");

	prio_unused_a: assert property (take && avs_read && hit(avs_address, ipr_pkg::OFF_PRIO0) // R17
		|=> (avs_readdata & 32'h1fff_1f1f) == 32'h0 && avs_readdata[23:21] == 3'h0)
		else $error("unused priority bits read nonzero");

	prio_write_a: assert property (bus_taken(ipr_pkg::OFF_PRIO0) ##0 avs_byteenable[3] // R12
		|=> prio_ff.dma == $past(avs_writedata[31:29]))
		else $error("dma priority not stored");

	irq_level_a: assert property (|(stat_ff & mask_ff) |=> irq)
		else $error("irq not raised");

endmodule : ipr_regs
`default_nettype wire
